// ### core/periph_disable_bank.sv
// Peripheral module disable bank: five control registers and per-peripheral gate outputs
`timescale 1ns/10ps
module periph_disable_bank (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire pmd_pkg::bus_req_t bus_req_in,
    input wire logic zero_cross_fuse_in,
    output logic [pmd_pkg::DATA_W-1:0] rdata_out,
    output pmd_pkg::periph_gate_t clock_stop_out,
    output pmd_pkg::periph_gate_t reset_hold_out,
    output pmd_pkg::periph_gate_t sfr_block_out
);

    logic [pmd_pkg::DATA_W-1:0] ctrl [pmd_pkg::REG_COUNT];
    logic zcd_forced;
    pmd_pkg::timer_osc_reg_t timer_reg;
    pmd_pkg::analog_reg_t analog_reg;
    pmd_pkg::waveform_reg_t wave_reg;
    pmd_pkg::compl_gen_reg_t compl_reg;
    pmd_pkg::serial_reg_t serial_reg;
    pmd_pkg::periph_gate_t next_gate;
    logic [pmd_pkg::DATA_W-1:0] next_rdata;

    function automatic logic reg_hit(input logic [pmd_pkg::ADDR_W-1:0] addr);
        reg_hit = (addr <= pmd_pkg::SERIAL_IDX);
    endfunction

    function automatic logic [pmd_pkg::DATA_W-1:0] reg_mask(
        input logic [pmd_pkg::ADDR_W-1:0] addr);
        case (addr)
            pmd_pkg::TIMER_OSC_IDX: begin
                reg_mask = pmd_pkg::TIMER_OSC_MASK;
            end
            pmd_pkg::ANALOG_IDX: begin
                reg_mask = pmd_pkg::ANALOG_MASK;
            end
            pmd_pkg::WAVEFORM_IDX: begin
                reg_mask = pmd_pkg::WAVEFORM_MASK;
            end
            pmd_pkg::COMPL_GEN_IDX: begin
                reg_mask = pmd_pkg::COMPL_GEN_MASK;
            end
            pmd_pkg::SERIAL_IDX: begin
                reg_mask = pmd_pkg::SERIAL_MASK;
            end
            default: begin
                reg_mask = pmd_pkg::READ_IDLE;
            end
        endcase
    endfunction

    // Fuse level comes from outside the clock domain
    pin_sync3 u_fuse_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(zero_cross_fuse_in),
        .level_out(zcd_forced)
    );

    // Control registers, masked on write
    for (genvar g = 0; g < pmd_pkg::REG_COUNT; g++) begin : g_ctrl
        always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
                ctrl[g] <= pmd_pkg::RESET_VALUE;
            end else if (bus_req_in.wr && bus_req_in.addr == pmd_pkg::ADDR_W'(g)) begin
                ctrl[g] <= bus_req_in.wdata & reg_mask(pmd_pkg::ADDR_W'(g));
            end
        end
    end

    // Read data stands for the cycle after the read strobe only
    always_comb begin
        next_rdata = pmd_pkg::READ_IDLE;
        if (bus_req_in.rd && reg_hit(bus_req_in.addr)) begin
            next_rdata = ctrl[bus_req_in.addr] & reg_mask(bus_req_in.addr);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= pmd_pkg::READ_IDLE;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    assign timer_reg = pmd_pkg::timer_osc_reg_t'(ctrl[pmd_pkg::TIMER_OSC_IDX]);
    assign analog_reg = pmd_pkg::analog_reg_t'(ctrl[pmd_pkg::ANALOG_IDX]);
    assign wave_reg = pmd_pkg::waveform_reg_t'(ctrl[pmd_pkg::WAVEFORM_IDX]);
    assign compl_reg = pmd_pkg::compl_gen_reg_t'(ctrl[pmd_pkg::COMPL_GEN_IDX]);
    assign serial_reg = pmd_pkg::serial_reg_t'(ctrl[pmd_pkg::SERIAL_IDX]);

    // Map register bits onto the per-peripheral gate vector
    always_comb begin
        next_gate = pmd_pkg::GATE_IDLE;
        next_gate.timers = timer_reg;
        next_gate.dac_unit_off = analog_reg.dac_unit_off;
        next_gate.adc_unit_off = analog_reg.adc_unit_off;
        next_gate.comparator2_off = analog_reg.comparator2_off;
        next_gate.comparator1_off = analog_reg.comparator1_off;
        next_gate.zero_cross_off = analog_reg.zero_cross_off & ~zcd_forced;
        next_gate.waves = wave_reg;
        next_gate.compl_gen3_off = compl_reg.compl_gen3_off;
        next_gate.compl_gen2_off = compl_reg.compl_gen2_off;
        next_gate.compl_gen1_off = compl_reg.compl_gen1_off;
        next_gate.uart_second_off = serial_reg.uart_second_off;
        next_gate.uart_first_off = serial_reg.uart_first_off;
        next_gate.spi_port_off = serial_reg.spi_port_off;
        next_gate.i2c_second_off = serial_reg.i2c_second_off;
        next_gate.i2c_first_off = serial_reg.i2c_first_off;
    end

    // Clock suspend per peripheral
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            clock_stop_out <= pmd_pkg::GATE_IDLE;
        end else begin
            clock_stop_out <= next_gate;
        end
    end

    // Reset hold; release returns the peripheral to its power-on state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reset_hold_out <= pmd_pkg::GATE_IDLE;
        end else begin
            reset_hold_out <= next_gate;
        end
    end

    // SFR blocking: writes dropped and reads forced to zero by the peripheral bus
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sfr_block_out <= pmd_pkg::GATE_IDLE;
        end else begin
            sfr_block_out <= next_gate;
        end
    end

    // Helper views for the checks below
    pmd_pkg::timer_osc_reg_t w_timer;
    pmd_pkg::analog_reg_t w_analog;
    pmd_pkg::waveform_reg_t w_wave;
    pmd_pkg::compl_gen_reg_t w_compl;
    pmd_pkg::serial_reg_t w_serial;
    logic [pmd_pkg::DATA_W-1:0] w_mask;

    assign w_timer = pmd_pkg::timer_osc_reg_t'(bus_req_in.wdata);
    assign w_analog = pmd_pkg::analog_reg_t'(bus_req_in.wdata);
    assign w_wave = pmd_pkg::waveform_reg_t'(bus_req_in.wdata);
    assign w_compl = pmd_pkg::compl_gen_reg_t'(bus_req_in.wdata);
    assign w_serial = pmd_pkg::serial_reg_t'(bus_req_in.wdata);
    assign w_mask = reg_mask(bus_req_in.addr);

    a_osc_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::TIMER_OSC_IDX)
        |-> ##2 (clock_stop_out.timers.numeric_osc_off == $past(w_timer.numeric_osc_off, 2)))
        else $error("numeric oscillator gate does not follow its write");

    a_timer_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::TIMER_OSC_IDX)
        |-> ##2 (clock_stop_out.timers.timer6_off == $past(w_timer.timer6_off, 2)
            && reset_hold_out.timers.timer0_off == $past(w_timer.timer0_off, 2)))
        else $error("timer gates do not follow their write");

    a_dac_adc_gate: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::ANALOG_IDX)
        |-> ##2 (clock_stop_out.dac_unit_off == $past(w_analog.dac_unit_off, 2)
            && clock_stop_out.adc_unit_off == $past(w_analog.adc_unit_off, 2)))
        else $error("converter gates do not follow their write");

    a_cmp_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::ANALOG_IDX)
        |-> ##2 (sfr_block_out.comparator2_off == $past(w_analog.comparator2_off, 2)
            && sfr_block_out.comparator1_off == $past(w_analog.comparator1_off, 2)))
        else $error("comparator gates do not follow their write");

    a_zcd_fuse_wins: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        zcd_forced |=> !clock_stop_out.zero_cross_off)
        else $error("zero-cross shut off while the fuse forces it on");

    a_zcd_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (!zcd_forced && analog_reg.zero_cross_off) |=> clock_stop_out.zero_cross_off)
        else $error("zero-cross gate missing while its bit is set");

    a_unimpl_read_zero: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        bus_req_in.rd |=> ((rdata_out & ~$past(w_mask)) == pmd_pkg::READ_IDLE))
        else $error("unimplemented bit reads as one");

    a_unimpl_write_drop: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        bus_req_in.wr |=> ((ctrl[$past(bus_req_in.addr)] & ~$past(w_mask))
            == pmd_pkg::READ_IDLE) || !$past(reg_hit(bus_req_in.addr)))
        else $error("unimplemented bit took a write");

    a_pwm_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::WAVEFORM_IDX)
        |-> ##2 (clock_stop_out.waves.pwm_unit8_off == $past(w_wave.pwm_unit8_off, 2)
            && clock_stop_out.waves.pwm_unit5_off == $past(w_wave.pwm_unit5_off, 2)))
        else $error("PWM gates do not follow their write");

    a_ccp_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::WAVEFORM_IDX)
        |-> ##2 (reset_hold_out.waves.capcomp4_off == $past(w_wave.capcomp4_off, 2)
            && reset_hold_out.waves.capcomp1_off == $past(w_wave.capcomp1_off, 2)))
        else $error("capture/compare gates do not follow their write");

    a_cwg_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::COMPL_GEN_IDX)
        |-> ##2 (clock_stop_out.compl_gen3_off == $past(w_compl.compl_gen3_off, 2)
            && clock_stop_out.compl_gen1_off == $past(w_compl.compl_gen1_off, 2)))
        else $error("complementary generator gates do not follow their write");

    a_uart_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::SERIAL_IDX)
        |-> ##2 (clock_stop_out.uart_second_off == $past(w_serial.uart_second_off, 2)
            && clock_stop_out.uart_first_off == $past(w_serial.uart_first_off, 2)))
        else $error("UART gates do not follow their write");

    a_spi_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::SERIAL_IDX)
        |-> ##2 (sfr_block_out.spi_port_off == $past(w_serial.spi_port_off, 2)))
        else $error("SPI gate does not follow its write");

    a_i2c_gate_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && bus_req_in.addr == pmd_pkg::SERIAL_IDX)
        |-> ##2 (sfr_block_out.i2c_second_off == $past(w_serial.i2c_second_off, 2)
            && sfr_block_out.i2c_first_off == $past(w_serial.i2c_first_off, 2)))
        else $error("I2C gates do not follow their write");

    a_reset_clears_all: assert property (
        @(posedge clk_in)
        !rst_n_in |=> (clock_stop_out == pmd_pkg::GATE_IDLE
            && reset_hold_out == pmd_pkg::GATE_IDLE && sfr_block_out == pmd_pkg::GATE_IDLE
            && ctrl[pmd_pkg::ANALOG_IDX] == pmd_pkg::RESET_VALUE
            && rdata_out == pmd_pkg::READ_IDLE && timer_reg == pmd_pkg::RESET_VALUE))
        else $error("reset left a disable bit or read data set");

    a_write_read_back: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && reg_hit(bus_req_in.addr)) ##1
        (bus_req_in.rd && bus_req_in.addr == $past(bus_req_in.addr))
        |=> (rdata_out == ($past(bus_req_in.wdata, 2) & $past(w_mask, 2))))
        else $error("read-back differs from the value written");

    a_gates_agree: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (clock_stop_out == reset_hold_out) && (reset_hold_out == sfr_block_out))
        else $error("clock, reset and SFR gates disagree");

    a_gate_one_edge: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        $changed(reset_hold_out) |-> $past(next_gate) != $past(next_gate, 2))
        else $error("gate changed without a register change one edge before");

    a_unmapped_read_zero: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.rd && !reg_hit(bus_req_in.addr)) |=> (rdata_out == pmd_pkg::READ_IDLE))
        else $error("unmapped address read back nonzero");

    a_unmapped_write_keep: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (bus_req_in.wr && !reg_hit(bus_req_in.addr))
        |=> ($stable(ctrl[pmd_pkg::TIMER_OSC_IDX]) && $stable(ctrl[pmd_pkg::ANALOG_IDX])
            && $stable(ctrl[pmd_pkg::WAVEFORM_IDX]) && $stable(ctrl[pmd_pkg::COMPL_GEN_IDX])
            && $stable(ctrl[pmd_pkg::SERIAL_IDX])))
        else $error("write to an unmapped address changed a register");

    a_read_idle_zero: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !bus_req_in.rd |=> (rdata_out == pmd_pkg::READ_IDLE))
        else $error("read data present without a read strobe");

    a_zcd_gate_clear: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !analog_reg.zero_cross_off |=> !clock_stop_out.zero_cross_off)
        else $error("zero-cross gate set while its bit is clear");

    a_regs_hold_idle: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !bus_req_in.wr
        |=> ($stable(ctrl[pmd_pkg::TIMER_OSC_IDX]) && $stable(ctrl[pmd_pkg::ANALOG_IDX])
            && $stable(ctrl[pmd_pkg::WAVEFORM_IDX]) && $stable(ctrl[pmd_pkg::COMPL_GEN_IDX])
            && $stable(ctrl[pmd_pkg::SERIAL_IDX])))
        else $error("register changed without a write");

    a_timer_full_map: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        clock_stop_out.timers == $past(timer_reg))
        else $error("timer and oscillator gates do not match their register");

    a_analog_full_map: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        reset_hold_out.dac_unit_off == $past(analog_reg.dac_unit_off)
            && reset_hold_out.adc_unit_off == $past(analog_reg.adc_unit_off)
            && reset_hold_out.comparator2_off == $past(analog_reg.comparator2_off)
            && reset_hold_out.comparator1_off == $past(analog_reg.comparator1_off))
        else $error("converter and comparator gates do not match their register");

    a_wave_full_map: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        reset_hold_out.waves == $past(wave_reg))
        else $error("PWM and capture/compare gates do not match their register");

    a_cwg_full_map: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        sfr_block_out.compl_gen3_off == $past(compl_reg.compl_gen3_off)
            && sfr_block_out.compl_gen2_off == $past(compl_reg.compl_gen2_off)
            && sfr_block_out.compl_gen1_off == $past(compl_reg.compl_gen1_off))
        else $error("complementary generator gates do not match their register");

    a_serial_full_map: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        clock_stop_out.uart_second_off == $past(serial_reg.uart_second_off)
            && clock_stop_out.uart_first_off == $past(serial_reg.uart_first_off)
            && clock_stop_out.spi_port_off == $past(serial_reg.spi_port_off)
            && clock_stop_out.i2c_second_off == $past(serial_reg.i2c_second_off)
            && clock_stop_out.i2c_first_off == $past(serial_reg.i2c_first_off))
        else $error("serial port gates do not match their register");

endmodule // periph_disable_bank

// ### core/pin_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync3 (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    output logic level_out
);

    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Stage one feeds stage two only
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            level_out <= 1'b0;
        end else if (stage2 == stage3) begin
            level_out <= stage3;
        end
    end

endmodule // pin_sync3

// ### core/pmd_pkg.sv
// Constants, register layouts and carrier types for the peripheral disable bank
package pmd_pkg;

    localparam int REG_COUNT = 5;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] TIMER_OSC_IDX = 3'h0;
    localparam logic [ADDR_W-1:0] ANALOG_IDX = 3'h1;
    localparam logic [ADDR_W-1:0] WAVEFORM_IDX = 3'h2;
    localparam logic [ADDR_W-1:0] COMPL_GEN_IDX = 3'h3;
    localparam logic [ADDR_W-1:0] SERIAL_IDX = 3'h4;

    localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

    // Implemented bits; all others ignore writes and read zero
    localparam logic [DATA_W-1:0] TIMER_OSC_MASK = 8'hff;
    localparam logic [DATA_W-1:0] ANALOG_MASK = 8'h67;
    localparam logic [DATA_W-1:0] WAVEFORM_MASK = 8'hff;
    localparam logic [DATA_W-1:0] COMPL_GEN_MASK = 8'he0;
    localparam logic [DATA_W-1:0] SERIAL_MASK = 8'h37;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic numeric_osc_off;
        logic timer6_off;
        logic timer5_off;
        logic timer4_off;
        logic timer3_off;
        logic timer2_off;
        logic timer1_off;
        logic timer0_off;
    } timer_osc_reg_t;

    typedef struct packed {
        logic unused7;
        logic dac_unit_off;
        logic adc_unit_off;
        logic [1:0] unused4_3;
        logic comparator2_off;
        logic comparator1_off;
        logic zero_cross_off;
    } analog_reg_t;

    typedef struct packed {
        logic pwm_unit8_off;
        logic pwm_unit7_off;
        logic pwm_unit6_off;
        logic pwm_unit5_off;
        logic capcomp4_off;
        logic capcomp3_off;
        logic capcomp2_off;
        logic capcomp1_off;
    } waveform_reg_t;

    typedef struct packed {
        logic compl_gen3_off;
        logic compl_gen2_off;
        logic compl_gen1_off;
        logic [4:0] unused4_0;
    } compl_gen_reg_t;

    typedef struct packed {
        logic [1:0] unused7_6;
        logic uart_second_off;
        logic uart_first_off;
        logic unused3;
        logic spi_port_off;
        logic i2c_second_off;
        logic i2c_first_off;
    } serial_reg_t;

    // One bit per peripheral, high while that peripheral is shut off
    typedef struct packed {
        timer_osc_reg_t timers;
        logic dac_unit_off;
        logic adc_unit_off;
        logic comparator2_off;
        logic comparator1_off;
        logic zero_cross_off;
        waveform_reg_t waves;
        logic compl_gen3_off;
        logic compl_gen2_off;
        logic compl_gen1_off;
        logic uart_second_off;
        logic uart_first_off;
        logic spi_port_off;
        logic i2c_second_off;
        logic i2c_first_off;
    } periph_gate_t;

    localparam periph_gate_t GATE_IDLE = '0;

endpackage

// ### verif/tb_top.sv
// Self-checking testbench for the peripheral disable bank
`timescale 1ns/10ps
module tb_top;
    logic clk_in;
    logic rst_n_in;
    pmd_pkg::bus_req_t bus_req_in;
    logic zero_cross_fuse_in;
    logic [pmd_pkg::DATA_W-1:0] rdata_out;
    pmd_pkg::periph_gate_t clock_stop_out;
    pmd_pkg::periph_gate_t reset_hold_out;
    pmd_pkg::periph_gate_t sfr_block_out;
    pmd_pkg::periph_gate_t exp_gate;
    pmd_pkg::periph_gate_t zmask;
    logic [7:0] exp_q[$];
    logic [7:0] drv_reg[5];
    logic [7:0] mdl_reg[5];
    logic fuse_eff;
    logic zc_skip;
    logic rd_taken;
    logic mon_on;
    int error_cnt;
    int total_checks;
    int seed;

    periph_disable_bank u_periph_disable_bank (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .bus_req_in(bus_req_in),
        .zero_cross_fuse_in(zero_cross_fuse_in),
        .rdata_out(rdata_out),
        .clock_stop_out(clock_stop_out),
        .reset_hold_out(reset_hold_out),
        .sfr_block_out(sfr_block_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // Implemented bits per register, zero for unmapped addresses
    function automatic logic [7:0] mask_of(input logic [2:0] a);
        case (a)
            3'h0: mask_of = 8'hff;
            3'h1: mask_of = 8'h67;
            3'h2: mask_of = 8'hff;
            3'h3: mask_of = 8'he0;
            3'h4: mask_of = 8'h37;
            default: mask_of = 8'h00;
        endcase
    endfunction

    function automatic pmd_pkg::periph_gate_t build_gate();
        pmd_pkg::periph_gate_t g;
        g = '0;
        g.timers = pmd_pkg::timer_osc_reg_t'(mdl_reg[0]);
        g.dac_unit_off = mdl_reg[1][6];
        g.adc_unit_off = mdl_reg[1][5];
        g.comparator2_off = mdl_reg[1][2];
        g.comparator1_off = mdl_reg[1][1];
        g.zero_cross_off = mdl_reg[1][0] & ~fuse_eff;
        g.waves = pmd_pkg::waveform_reg_t'(mdl_reg[2]);
        g.compl_gen3_off = mdl_reg[3][7];
        g.compl_gen2_off = mdl_reg[3][6];
        g.compl_gen1_off = mdl_reg[3][5];
        g.uart_second_off = mdl_reg[4][5];
        g.uart_first_off = mdl_reg[4][4];
        g.spi_port_off = mdl_reg[4][2];
        g.i2c_second_off = mdl_reg[4][1];
        g.i2c_first_off = mdl_reg[4][0];
        return g;
    endfunction

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_gate(input string what, input pmd_pkg::periph_gate_t exp,
                              input pmd_pkg::periph_gate_t got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Register model, gates follow one edge after the register
    always @(posedge clk_in) begin
        mon_on <= 1'b1;
        rd_taken <= rst_n_in & bus_req_in.rd;
        if (!rst_n_in) begin
            exp_gate <= '0;
            for (int i = 0; i < 5; i++) begin
                mdl_reg[i] <= 8'h00;
            end
        end else begin
            exp_gate <= build_gate();
            if (bus_req_in.wr && bus_req_in.addr < 3'h5) begin
                mdl_reg[bus_req_in.addr] <= bus_req_in.wdata & mask_of(bus_req_in.addr);
            end
        end
    end

    always @(negedge clk_in) begin
        if (mon_on) begin
            zmask = '1;
            zmask.zero_cross_off = ~zc_skip;
            if (rd_taken) begin
                check8("rdata_out", exp_q.pop_front(), rdata_out);
            end else begin
                check8("rdata_out idle", 8'h00, rdata_out);
            end
            check_gate("clock_stop_out", exp_gate & zmask, clock_stop_out & zmask);
            check_gate("reset_hold_out", exp_gate & zmask, reset_hold_out & zmask);
            check_gate("sfr_block_out", exp_gate & zmask, sfr_block_out & zmask);
        end
    end

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        bus_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        if (a < 3'h5) drv_reg[a] = d & mask_of(a);
        @(posedge clk_in);
    endtask

    task automatic rd_reg(input logic [2:0] a);
        bus_req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back((a < 3'h5) ? drv_reg[a] : 8'h00);
        @(posedge clk_in);
    endtask

    task automatic idle(input int n);
        bus_req_in <= '0;
        repeat (n) @(posedge clk_in);
    endtask

    task automatic do_reset(input int n);
        rst_n_in <= 1'b0;
        bus_req_in <= '0;
        for (int i = 0; i < 5; i++) begin
            drv_reg[i] = 8'h00;
        end
        repeat (n) @(posedge clk_in);
        rst_n_in <= 1'b1;
    endtask

    task automatic print_verdict();
        $display("Checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        print_verdict();
    end

    initial begin
        logic [2:0] a;
        logic [7:0] d;
        seed = 26051;
        error_cnt = 0;
        total_checks = 0;
        rst_n_in = 1'b0;
        bus_req_in = '0;
        zero_cross_fuse_in = 1'b0;
        fuse_eff = 1'b0;
        zc_skip = 1'b0;
        @(posedge clk_in);
        do_reset(5);
        @(posedge clk_in);
        // Reset values, then every bit of every address alone
        for (int r = 0; r < 5; r++) rd_reg(3'(r));
        for (int r = 0; r < 8; r++) begin
            for (int b = 0; b < 8; b++) begin
                wr_reg(3'(r), 8'h01 << b);
                rd_reg(3'(r));
                idle(1);
            end
        end
        // All ones back to back, then cleared
        for (int r = 0; r < 8; r++) wr_reg(3'(r), 8'hff);
        for (int r = 0; r < 8; r++) rd_reg(3'(r));
        for (int r = 0; r < 8; r++) wr_reg(3'(r), 8'h00);
        idle(1);
        for (int r = 0; r < 8; r++) rd_reg(3'(r));
        // Random traffic with no gaps
        repeat (300) begin
            a = 3'($random(seed));
            d = 8'($random(seed));
            if ($random(seed) & 1) begin
                wr_reg(a, d);
            end else begin
                rd_reg(a);
            end
        end
        // Fuse keeps zero-cross running while its bit still reads back
        wr_reg(3'h1, 8'h01);
        idle(1);
        zc_skip = 1'b1;
        zero_cross_fuse_in <= 1'b1;
        idle(8);
        fuse_eff = 1'b1;
        idle(2);
        zc_skip = 1'b0;
        rd_reg(3'h1);
        wr_reg(3'h1, 8'h00);
        wr_reg(3'h1, 8'h01);
        idle(3);
        zc_skip = 1'b1;
        zero_cross_fuse_in <= 1'b0;
        idle(8);
        fuse_eff = 1'b0;
        idle(2);
        zc_skip = 1'b0;
        idle(2);
        // Reset in mid-run clears every bit
        wr_reg(3'h0, 8'hff);
        wr_reg(3'h2, 8'ha5);
        wr_reg(3'h4, 8'hff);
        idle(2);
        do_reset(4);
        @(posedge clk_in);
        for (int r = 0; r < 5; r++) rd_reg(3'(r));
        idle(4);
        print_verdict();
    end
endmodule // tb_top
